// [rtl/smrx_regs.vh]
`ifndef SMRX_REGS_VH
`define SMRX_REGS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define SMRX_IDX_FSK_RATE_INDEX 12'h1f9
`define SMRX_IDX_FSK_FEC_FRAME 12'h1fa
`define SMRX_IDX_OFDM_RX 12'h1fb
`define SMRX_IDX_RX_METHOD 12'h1fc
`define SMRX_ADDR_W 14
`define SMRX_ADDR_FSK_RATE_INDEX {`SMRX_IDX_FSK_RATE_INDEX, 2'b00}
`define SMRX_ADDR_FSK_FEC_FRAME {`SMRX_IDX_FSK_FEC_FRAME, 2'b00}
`define SMRX_ADDR_OFDM_RX {`SMRX_IDX_OFDM_RX, 2'b00}
`define SMRX_ADDR_RX_METHOD {`SMRX_IDX_RX_METHOD, 2'b00}

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define SMRX_RST_FSK_RATE_INDEX 8'h00
`define SMRX_RST_FSK_FEC_FRAME 8'h20
`define SMRX_RST_OFDM_RX 8'h00
`define SMRX_RST_RX_METHOD 8'h00
`define SMRX_MASK_FSK_RATE_INDEX 8'h1f
`define SMRX_MASK_FSK_FEC_FRAME 8'h3f
`define SMRX_MASK_OFDM_RX 8'h1f
`define SMRX_MASK_RX_METHOD 8'h01

// ----------------------------------------
// field positions
// ----------------------------------------
`define SMRX_B_MOD_INDEX 0
`define SMRX_B_RATE_LO 1
`define SMRX_B_RATE_HI 4
`define SMRX_B_FEC_EN 0
`define SMRX_B_FEC_TYPE 1
`define SMRX_B_FSK_ILV 2
`define SMRX_B_FEC_AUTO 3
`define SMRX_B_SFD 4
`define SMRX_B_FORCE_MS 5
`define SMRX_B_CRC_LEN 0
`define SMRX_B_OPT_LO 1
`define SMRX_B_OPT_HI 2
`define SMRX_B_OFDM_ILV 3
`define SMRX_B_OFDM_EXT 4
`define SMRX_B_METHOD 0

// ----------------------------------------
// fsk rate codes and rates in 0.1 kbps
// ----------------------------------------
`define SMRX_RATE_50K 4'h0
`define SMRX_RATE_100K 4'h1
`define SMRX_RATE_150K 4'h2
`define SMRX_RATE_200K 4'h3
`define SMRX_RATE_10K 4'h4
`define SMRX_RATE_20K 4'h5
`define SMRX_RATE_9K6 4'h8
`define SMRX_RATE_19K2 4'h9
`define SMRX_RATE_38K4 4'ha
`define SMRX_RATE_115K2 4'hb
`define SMRX_KBPS10_W 11

`endif

// [rtl/smrx_rate_decode.v]
`include "smrx_regs.vh"

// maps the fsk rate code to a rate in 0.1 kbps steps
module smrx_rate_decode (
    input wire [3:0] rate_code,
    output reg [`SMRX_KBPS10_W-1:0] rate_kbps_x10,
    output reg rate_legal
);

    // ----------------------------------------
    // rate lookup
    // ----------------------------------------
    // prohibited codes report rate zero and legal low
    always @* begin
        rate_legal = 1'b1;
        case (rate_code)
            `SMRX_RATE_50K: rate_kbps_x10 = 11'h1f4;
            `SMRX_RATE_100K: rate_kbps_x10 = 11'h3e8;
            `SMRX_RATE_150K: rate_kbps_x10 = 11'h5dc;
            `SMRX_RATE_200K: rate_kbps_x10 = 11'h7d0;
            `SMRX_RATE_10K: rate_kbps_x10 = 11'h064;
            `SMRX_RATE_20K: rate_kbps_x10 = 11'h0c8;
            `SMRX_RATE_9K6: rate_kbps_x10 = 11'h060;
            `SMRX_RATE_19K2: rate_kbps_x10 = 11'h0c0;
            `SMRX_RATE_38K4: rate_kbps_x10 = 11'h180;
            `SMRX_RATE_115K2: rate_kbps_x10 = 11'h480;
            default: begin
                rate_kbps_x10 = 11'h000;
                rate_legal = 1'b0;
            end
        endcase
    end

endmodule

// [rtl/smrx_cfg_top.v]
// Added by the designer: the APB slave port.
`include "smrx_regs.vh"

module smrx_cfg_top (
    // clock and asynchronous active-low reset
    input wire pclk,
    input wire presetn,
    // apb slave, one access cycle, no wait states
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SMRX_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    // registered answer, one cycle wide
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // received mode-switch bit, same clock
    input wire mode_switch_rx,
    output reg mode_switch_bit,
    // fsk settings for the switched mode
    output reg [3:0] fsk_rate_sel,
    output reg [`SMRX_KBPS10_W-1:0] fsk_rate_kbps_x10,
    output reg fsk_rate_legal,
    output reg fsk_mod_index_sel,
    output reg force_ms_clear,
    output reg sfd_value_sel,
    output reg fec_auto_detect_en,
    output reg fsk_interleave_en,
    output reg fec_encoder_type,
    output reg fsk_fec_en,
    // ofdm settings for the switched mode
    output reg ofdm_extended_mode,
    output reg ofdm_interleave_value,
    output reg [1:0] ofdm_option_sel,
    output reg ofdm_crc_length_sel,
    output reg ofdm_crc_is_32,
    // method select and its one-hot flags
    output reg rx_method_sel,
    output reg fsk_cfg_active,
    output reg ofdm_cfg_active
);

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    // stored images; reserved bits never stored
    reg [7:0] fsk_rate_index_config_reg;
    reg [7:0] fsk_fec_frame_config_reg;
    reg [7:0] ofdm_rx_config_reg;
    reg [7:0] rx_method_config_reg;

    // next values from the write decode
    reg [7:0] fsk_rate_index_config_next;
    reg [7:0] fsk_fec_frame_config_next;
    reg [7:0] ofdm_rx_config_next;
    reg [7:0] rx_method_config_next;

    // ----------------------------------------
    // bus decode signals
    // ----------------------------------------
    // transfer phases
    wire setup_phase;
    wire write_commit;

    // one select per mapped word
    wire hit_fsk0;
    wire hit_fsk1;
    wire hit_ofdm;
    wire hit_method;
    wire addr_mapped;

    // write byte and its lane enable
    wire lane0_en;
    wire [7:0] wbyte;

    // rate lookup result, registered below
    wire [`SMRX_KBPS10_W-1:0] rate_kbps_dec;
    wire rate_legal_dec;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // exact word match; the low two address bits must be zero
    function addr_is;
        input [`SMRX_ADDR_W-1:0] a;
        input [`SMRX_ADDR_W-1:0] target;
        begin
            addr_is = (a == target);
        end
    endfunction

    // merge written data under the writable mask, reserved stay zero
    // masking once on write keeps the read path a plain mux
    function [7:0] masked_write;
        input [7:0] data;
        input [7:0] mask;
        begin
            masked_write = data & mask;
        end
    endfunction

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one hit per word; no hit raises the error flag
    assign hit_fsk0 = addr_is(paddr, `SMRX_ADDR_FSK_RATE_INDEX);
    assign hit_fsk1 = addr_is(paddr, `SMRX_ADDR_FSK_FEC_FRAME);
    assign hit_ofdm = addr_is(paddr, `SMRX_ADDR_OFDM_RX);
    assign hit_method = addr_is(paddr, `SMRX_ADDR_RX_METHOD);
    assign addr_mapped = hit_fsk0 | hit_fsk1 | hit_ofdm | hit_method;

    // setup cycle: answer is prepared here so access lasts one cycle
    assign setup_phase = psel & ~penable;
    // writes land only at the completing access edge, never on error
    assign write_commit = psel & penable & pready & pwrite & ~pslverr;
    // registers live in byte lane 0; other lanes are ignored
    assign lane0_en = pstrb[0];
    assign wbyte = pwdata[7:0];

    // ----------------------------------------
    // next register values
    // ----------------------------------------
    // hold, unless a committed lane-0 write loads the byte
    always @* begin
        fsk_rate_index_config_next = fsk_rate_index_config_reg;
        fsk_fec_frame_config_next = fsk_fec_frame_config_reg;
        ofdm_rx_config_next = ofdm_rx_config_reg;
        rx_method_config_next = rx_method_config_reg;
        if (write_commit && lane0_en) begin
            // reserved bits masked off on write, so they read zero
            if (hit_fsk0) begin
                fsk_rate_index_config_next =
                    masked_write(wbyte, `SMRX_MASK_FSK_RATE_INDEX);
            end
            if (hit_fsk1) begin
                fsk_fec_frame_config_next =
                    masked_write(wbyte, `SMRX_MASK_FSK_FEC_FRAME);
            end
            if (hit_ofdm) begin
                ofdm_rx_config_next =
                    masked_write(wbyte, `SMRX_MASK_OFDM_RX);
            end
            if (hit_method) begin
                rx_method_config_next =
                    masked_write(wbyte, `SMRX_MASK_RX_METHOD);
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // only the force-clear bit starts set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsk_rate_index_config_reg <= `SMRX_RST_FSK_RATE_INDEX;
            fsk_fec_frame_config_reg <= `SMRX_RST_FSK_FEC_FRAME;
            ofdm_rx_config_reg <= `SMRX_RST_OFDM_RX;
            rx_method_config_reg <= `SMRX_RST_RX_METHOD;
        end else begin
            fsk_rate_index_config_reg <= fsk_rate_index_config_next;
            fsk_fec_frame_config_reg <= fsk_fec_frame_config_next;
            ofdm_rx_config_reg <= ofdm_rx_config_next;
            rx_method_config_reg <= rx_method_config_next;
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    // one wait-free access: pready rises for the access cycle only;
    // read data is captured at setup so it is stable all access long
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= ~addr_mapped;
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
                // upper 24 bits and reserved bits stay zero
                // hits are exclusive, so the order is moot
                if (hit_fsk0) begin
                    prdata[7:0] <= fsk_rate_index_config_reg;
                end
                if (hit_fsk1) begin
                    prdata[7:0] <= fsk_fec_frame_config_reg;
                end
                if (hit_ofdm) begin
                    prdata[7:0] <= ofdm_rx_config_reg;
                end
                if (hit_method) begin
                    prdata[7:0] <= rx_method_config_reg;
                end
            end
        end else begin
            // idle or access edge: the answer drops
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // rate decode
    // ----------------------------------------
    // fed from the next value so the decoded rate lands with the field
    // prohibited codes are stored; the lookup flags them
    smrx_rate_decode u_rate_decode (
        .rate_code(fsk_rate_index_config_next[`SMRX_B_RATE_HI:`SMRX_B_RATE_LO]),
        .rate_kbps_x10(rate_kbps_dec),
        .rate_legal(rate_legal_dec)
    );

    // ----------------------------------------
    // fsk field outputs
    // ----------------------------------------
    // outputs track the next values so each appears with its register
    // reset rate code zero decodes to its table entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsk_rate_sel <= 4'h0;
            fsk_rate_kbps_x10 <= 11'h1f4;
            fsk_rate_legal <= 1'b1;
            fsk_mod_index_sel <= 1'b0;
        end else begin
            fsk_rate_sel <=
                fsk_rate_index_config_next[`SMRX_B_RATE_HI:`SMRX_B_RATE_LO];
            fsk_rate_kbps_x10 <= rate_kbps_dec;
            fsk_rate_legal <= rate_legal_dec;
            fsk_mod_index_sel <=
                fsk_rate_index_config_next[`SMRX_B_MOD_INDEX];
        end
    end

    // fec, interleave, sfd and force-clear controls
    // each a straight copy of its stored bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_ms_clear <= 1'b1;
            sfd_value_sel <= 1'b0;
            fec_auto_detect_en <= 1'b0;
            fsk_interleave_en <= 1'b0;
            fec_encoder_type <= 1'b0;
            fsk_fec_en <= 1'b0;
        end else begin
            force_ms_clear <= fsk_fec_frame_config_next[`SMRX_B_FORCE_MS];
            sfd_value_sel <= fsk_fec_frame_config_next[`SMRX_B_SFD];
            fec_auto_detect_en <=
                fsk_fec_frame_config_next[`SMRX_B_FEC_AUTO];
            fsk_interleave_en <=
                fsk_fec_frame_config_next[`SMRX_B_FSK_ILV];
            fec_encoder_type <=
                fsk_fec_frame_config_next[`SMRX_B_FEC_TYPE];
            fsk_fec_en <= fsk_fec_frame_config_next[`SMRX_B_FEC_EN];
        end
    end

    // ----------------------------------------
    // mode-switch bit filter
    // ----------------------------------------
    // same-clock input from the demodulator, so no synchroniser;
    // one cycle of latency buys a flop-driven output
    // force bit comes from the stored register, so clearing it
    // lets the received bit through from the edge after the write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_switch_bit <= 1'b0;
        end else if (fsk_fec_frame_config_reg[`SMRX_B_FORCE_MS]) begin
            mode_switch_bit <= 1'b0;
        end else begin
            mode_switch_bit <= mode_switch_rx;
        end
    end

    // ----------------------------------------
    // ofdm field outputs
    // ----------------------------------------
    // extended mode is passed through as written; it is not checked
    // against option and mcs, which software must keep consistent
    // option field sits above the crc bit;
    // crc length kept in both senses for the crc checker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofdm_extended_mode <= 1'b0;
            ofdm_interleave_value <= 1'b0;
            ofdm_option_sel <= 2'h0;
            ofdm_crc_length_sel <= 1'b0;
            ofdm_crc_is_32 <= 1'b1;
        end else begin
            ofdm_extended_mode <= ofdm_rx_config_next[`SMRX_B_OFDM_EXT];
            ofdm_interleave_value <=
                ofdm_rx_config_next[`SMRX_B_OFDM_ILV];
            ofdm_option_sel <=
                ofdm_rx_config_next[`SMRX_B_OPT_HI:`SMRX_B_OPT_LO];
            ofdm_crc_length_sel <= ofdm_rx_config_next[`SMRX_B_CRC_LEN];
            // zero means 32-bit crc, one means 16-bit
            ofdm_crc_is_32 <= ~ofdm_rx_config_next[`SMRX_B_CRC_LEN];
        end
    end

    // ----------------------------------------
    // reception method selection
    // ----------------------------------------
    // exactly one configuration set is flagged active at any time
    // both flags come from one stored bit, so they cannot
    // disagree or both drop during a rewrite
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_method_sel <= 1'b0;
            fsk_cfg_active <= 1'b1;
            ofdm_cfg_active <= 1'b0;
        end else begin
            rx_method_sel <= rx_method_config_next[`SMRX_B_METHOD];
            fsk_cfg_active <= ~rx_method_config_next[`SMRX_B_METHOD];
            ofdm_cfg_active <= rx_method_config_next[`SMRX_B_METHOD];
        end
    end

endmodule

// [testbench/smrx_cfg_props.sv]
`include "smrx_regs.vh"

// ----------------------------------------
// bus and field checks on the top pins
// ----------------------------------------
// sees only top pins, so it survives any rewrite of the bodies
module smrx_cfg_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SMRX_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire mode_switch_rx,
    input wire mode_switch_bit,
    input wire [3:0] fsk_rate_sel,
    input wire fsk_rate_legal,
    input wire fsk_mod_index_sel,
    input wire force_ms_clear,
    input wire sfd_value_sel,
    input wire fec_auto_detect_en,
    input wire fsk_interleave_en,
    input wire fec_encoder_type,
    input wire fsk_fec_en,
    input wire ofdm_extended_mode,
    input wire ofdm_interleave_value,
    input wire [1:0] ofdm_option_sel,
    input wire ofdm_crc_length_sel,
    input wire ofdm_crc_is_32,
    input wire rx_method_sel,
    input wire fsk_cfg_active,
    input wire ofdm_cfg_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // accepted write at this edge, and address decode
    wire wr_ok;
    wire mapped;
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign mapped = paddr inside {`SMRX_ADDR_FSK_RATE_INDEX, `SMRX_ADDR_FSK_FEC_FRAME,
        `SMRX_ADDR_OFDM_RX, `SMRX_ADDR_RX_METHOD};

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_rsvd_read_zero: assert property (pready |-> prdata[31:6] == 26'h000_0000 &&
        (paddr == `SMRX_ADDR_FSK_FEC_FRAME || !prdata[5]) &&
        (paddr != `SMRX_ADDR_RX_METHOD || prdata[4:1] == 4'h0))
        else $error("reserved read bits set");
    a_rate_write: assert property (wr_ok && paddr == `SMRX_ADDR_FSK_RATE_INDEX
        |=> {fsk_rate_sel, fsk_mod_index_sel} == $past(pwdata[4:0]))
        else $error("rate fields not written");
    a_fec_write: assert property (
        wr_ok && paddr == `SMRX_ADDR_FSK_FEC_FRAME
        |=> {force_ms_clear, sfd_value_sel, fec_auto_detect_en, fsk_interleave_en,
        fec_encoder_type, fsk_fec_en} == $past(pwdata[5:0]))
        else $error("fec fields not written");
    a_ofdm_write: assert property (wr_ok && paddr == `SMRX_ADDR_OFDM_RX
        |=> {ofdm_extended_mode, ofdm_interleave_value, ofdm_option_sel,
        ofdm_crc_length_sel} == $past(pwdata[4:0]))
        else $error("ofdm fields not written");
    a_ms_gate: assert property (
        mode_switch_bit == ($past(mode_switch_rx) && !$past(force_ms_clear)))
        else $error("mode switch bit gating wrong");
    a_crc_len: assert property (ofdm_crc_is_32 == !ofdm_crc_length_sel)
        else $error("crc length flag wrong");
    a_method_pick: assert property (fsk_cfg_active == !rx_method_sel &&
        ofdm_cfg_active == rx_method_sel)
        else $error("method select wrong");
    a_rate_legal: assert property (
        fsk_rate_legal == (fsk_rate_sel inside {[4'h0:4'h5], [4'h8:4'hb]}))
        else $error("rate legal flag wrong");
endmodule

bind smrx_cfg_top smrx_cfg_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_switch_rx(mode_switch_rx), .mode_switch_bit(mode_switch_bit),
    .fsk_rate_sel(fsk_rate_sel), .fsk_rate_legal(fsk_rate_legal),
    .fsk_mod_index_sel(fsk_mod_index_sel), .force_ms_clear(force_ms_clear),
    .sfd_value_sel(sfd_value_sel), .fec_auto_detect_en(fec_auto_detect_en),
    .fsk_interleave_en(fsk_interleave_en), .fec_encoder_type(fec_encoder_type),
    .fsk_fec_en(fsk_fec_en), .ofdm_extended_mode(ofdm_extended_mode),
    .ofdm_interleave_value(ofdm_interleave_value), .ofdm_option_sel(ofdm_option_sel),
    .ofdm_crc_length_sel(ofdm_crc_length_sel), .ofdm_crc_is_32(ofdm_crc_is_32),
    .rx_method_sel(rx_method_sel), .fsk_cfg_active(fsk_cfg_active),
    .ofdm_cfg_active(ofdm_cfg_active)
);

// [testbench/smrx_cfg_top_test.sv]
`include "smrx_regs.vh"

module smrx_cfg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [13:0] a; logic [7:0] w; logic [7:0] r; logic [16:0] o;} smrx_row_t;
    localparam logic [13:0] a_rate = `SMRX_ADDR_FSK_RATE_INDEX;
    localparam logic [13:0] a_fec = `SMRX_ADDR_FSK_FEC_FRAME;
    localparam logic [13:0] a_ofdm = `SMRX_ADDR_OFDM_RX;
    localparam logic [13:0] a_meth = `SMRX_ADDR_RX_METHOD;
    logic pclk, presetn, psel, penable, pwrite, mode_switch_rx;
    logic [13:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] pstrb;
    logic er;
    wire [31:0] prdata;
    wire pready, pslverr, mode_switch_bit, fsk_rate_legal, fsk_mod_index_sel, force_ms_clear;
    wire sfd_value_sel, fec_auto_detect_en, fsk_interleave_en, fec_encoder_type, fsk_fec_en;
    wire ofdm_extended_mode, ofdm_interleave_value, ofdm_crc_length_sel, ofdm_crc_is_32;
    wire rx_method_sel, fsk_cfg_active, ofdm_cfg_active;
    wire [3:0] fsk_rate_sel;
    wire [10:0] fsk_rate_kbps_x10;
    wire [1:0] ofdm_option_sel;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [13:0] ra [4] = '{a_rate, a_fec, a_ofdm, a_meth};
    logic [7:0] rv [4] = '{8'h00, 8'h20, 8'h00, 8'h00};
    logic [7:0] rm [3] = '{8'h1f, 8'h3f, 8'h1f};
    // address, written, read back, outputs seen
    smrx_row_t rows [20] = '{
        '{a_rate, 8'h01, 8'h01, {1'b1, 11'h1f4, 4'h0, 1'b1}},
        '{a_rate, 8'h02, 8'h02, {1'b1, 11'h3e8, 4'h1, 1'b0}},
        '{a_rate, 8'h05, 8'h05, {1'b1, 11'h5dc, 4'h2, 1'b1}},
        '{a_rate, 8'h06, 8'h06, {1'b1, 11'h7d0, 4'h3, 1'b0}},
        '{a_rate, 8'h09, 8'h09, {1'b1, 11'h064, 4'h4, 1'b1}},
        '{a_rate, 8'h0a, 8'h0a, {1'b1, 11'h0c8, 4'h5, 1'b0}},
        '{a_rate, 8'h11, 8'h11, {1'b1, 11'h060, 4'h8, 1'b1}},
        '{a_rate, 8'h12, 8'h12, {1'b1, 11'h0c0, 4'h9, 1'b0}},
        '{a_rate, 8'h15, 8'h15, {1'b1, 11'h180, 4'ha, 1'b1}},
        '{a_rate, 8'h16, 8'h16, {1'b1, 11'h480, 4'hb, 1'b0}},
        '{a_rate, 8'h0d, 8'h0d, {1'b0, 11'h000, 4'h6, 1'b1}},
        '{a_rate, 8'h1e, 8'h1e, {1'b0, 11'h000, 4'hf, 1'b0}},
        '{a_fec, 8'h2a, 8'h2a, {11'h000, 6'h2a}},
        '{a_fec, 8'h15, 8'h15, {11'h000, 6'h15}},
        '{a_ofdm, 8'h00, 8'h00, {11'h000, 1'b1, 5'h00}},
        '{a_ofdm, 8'h03, 8'h03, {11'h000, 1'b0, 5'h03}},
        '{a_ofdm, 8'h0c, 8'h0c, {11'h000, 1'b1, 5'h0c}},
        '{a_ofdm, 8'h17, 8'h17, {11'h000, 1'b0, 5'h17}},
        '{a_meth, 8'h01, 8'h01, {14'h0000, 3'b101}},
        '{a_meth, 8'h00, 8'h00, {14'h0000, 3'b010}}};

    smrx_cfg_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_switch_rx(mode_switch_rx), .mode_switch_bit(mode_switch_bit),
        .fsk_rate_sel(fsk_rate_sel), .fsk_rate_kbps_x10(fsk_rate_kbps_x10),
        .fsk_rate_legal(fsk_rate_legal), .fsk_mod_index_sel(fsk_mod_index_sel),
        .force_ms_clear(force_ms_clear), .sfd_value_sel(sfd_value_sel),
        .fec_auto_detect_en(fec_auto_detect_en), .fsk_interleave_en(fsk_interleave_en),
        .fec_encoder_type(fec_encoder_type), .fsk_fec_en(fsk_fec_en),
        .ofdm_extended_mode(ofdm_extended_mode), .ofdm_interleave_value(ofdm_interleave_value),
        .ofdm_option_sel(ofdm_option_sel), .ofdm_crc_length_sel(ofdm_crc_length_sel),
        .ofdm_crc_is_32(ofdm_crc_is_32), .rx_method_sel(rx_method_sel),
        .fsk_cfg_active(fsk_cfg_active), .ofdm_cfg_active(ofdm_cfg_active));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // outputs that belong to one register, packed as in the rows
    function automatic logic [16:0] obs(input logic [13:0] a);
        case (a)
            a_rate: return {fsk_rate_legal, fsk_rate_kbps_x10, fsk_rate_sel, fsk_mod_index_sel};
            a_fec: return {11'h000, force_ms_clear, sfd_value_sel, fec_auto_detect_en,
                fsk_interleave_en, fec_encoder_type, fsk_fec_en};
            a_ofdm: return {11'h000, ofdm_crc_is_32, ofdm_extended_mode, ofdm_interleave_value,
                ofdm_option_sel, ofdm_crc_length_sel};
            default: return {14'h0000, ofdm_cfg_active, fsk_cfg_active, rx_method_sel};
        endcase
    endfunction

    task summarize;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one transfer; read data and error are taken at the ready edge
    task apb(input logic w, input logic [13:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            summarize();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rst_check;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 8'h00, 4'h1);
            chk("reset value", {24'h00_0000, rv[i]}, rd);
        end
        chk("reset fec outputs", 32'h0000_0020, 32'(obs(a_fec)));
    endtask

    // ----------------------------------------
    // clock and main sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, mode_switch_rx} = 5'b00000;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_check();
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w, 4'h1);
            apb(1'b0, rows[i].a, 8'h00, 4'h1);
            chk("readback", {24'h00_0000, rows[i].r}, rd);
            chk("outputs", 32'(rows[i].o), 32'(obs(rows[i].a)));
        end
        // reserved bits are dropped, not stored
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ra[i], 8'hff, 4'h1);
            apb(1'b0, ra[i], 8'h00, 4'h1);
            chk("reserved bits", {24'h00_0000, rm[i]}, rd);
        end
        // write with byte lane off must leave the register alone
        apb(1'b1, a_fec, 8'h00, 4'he);
        apb(1'b0, a_fec, 8'h00, 4'h1);
        chk("strobe off", 32'h0000_003f, rd);
        // unmapped word next to the block
        apb(1'b1, 14'h07e0, 8'hff, 4'h1);
        chk("write error", 32'h0000_0001, {31'h0000_0000, er});
        apb(1'b0, 14'h07f4, 8'h00, 4'h1);
        chk("read error", 32'h0000_0001, {31'h0000_0000, er});
        chk("unmapped data", 32'h0000_0000, rd);
        // force bit is set here, so the received bit must stay low
        @(posedge pclk);
        mode_switch_rx <= 1'b1;
        repeat (2) @(negedge pclk);
        chk("ms forced", 32'h0000_0000, {31'h0000_0000, mode_switch_bit});
        apb(1'b1, a_fec, 8'h00, 4'h1);
        repeat (2) @(negedge pclk);
        chk("ms passed", 32'h0000_0001, {31'h0000_0000, mode_switch_bit});
        @(posedge pclk);
        mode_switch_rx <= 1'b0;
        repeat (2) @(negedge pclk);
        chk("ms low", 32'h0000_0000, {31'h0000_0000, mode_switch_bit});
        // second reset in mid run restores every field
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_check();
        summarize();
    end
endmodule
